/* core/osccs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module osccs_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire osccs_pkg::osccs_cfg_t cfg,
	input wire logic osc_in_pin,
	input wire logic int_osc_clk,
	input wire logic hf_ready,
	input wire logic lf_ready,
	input wire logic power_up_timer_done,
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output osccs_pkg::osccs_pins_t pins,
	output logic [1:0] gain_sel,
	output osccs_pkg::osccs_src_t sys_src,
	output logic hf_enable,
	output logic lf_enable,
	output logic cpu_hold,
	output logic irq
);

	// Sequencer states
	typedef enum logic [2:0] {
		ST_CAPTURE,
		ST_POWER_UP_TIMER,
		ST_STARTUP,
		ST_RUN,
		ST_SWITCH,
		ST_SLEEP
	} osccs_state_t;

	// Crystal mode decode, used in several places
	function automatic logic is_crystal(input osccs_pkg::osccs_mode_t m);
		is_crystal = (m == osccs_pkg::low_power_crystal_mode) ||
			(m == osccs_pkg::medium_gain_crystal_mode) ||
			(m == osccs_pkg::high_gain_crystal_mode);
	endfunction

	// Internal oscillator mode decode
	function automatic logic is_internal(input osccs_pkg::osccs_mode_t m);
		is_internal = (m == osccs_pkg::internal_osc_clkout_mode) ||
			(m == osccs_pkg::internal_osc_pins_free_mode);
	endfunction

	// Synchronisers for pins and analog ready levels
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [1:0] edge_q;
	// Captured straps
	osccs_pkg::osccs_cfg_t cfg_q;
	// Control fields
	logic [2:0] freq_q;
	logic sys_sel_q;
	logic startup_q;
	// Interrupt registers
	logic [osccs_pkg::IRQ_W-1:0] irq_stat_q;
	logic [osccs_pkg::IRQ_W-1:0] irq_mask_q;
	// Sequencer
	osccs_state_t state_q;
	osccs_pkg::osccs_src_t src_q;
	logic fail_q;
	logic [10:0] ost_cnt_q;
	logic [8:0] warm_cnt_q;
	logic [10:0] fail_cnt_q;
	logic [1:0] div_q;
	// Registered outputs
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	osccs_pkg::osccs_pins_t pins_q;
	logic [1:0] gain_q;
	logic hf_en_q;
	logic lf_en_q;
	logic hold_q;
	logic irq_q;

	// Synchronised levels
	wire logic osc_in_s = sync2_q[0];
	wire logic int_clk_s = sync2_q[1];
	wire logic hf_ok = sync2_q[2];
	wire logic lf_ok = sync2_q[3];
	// Rising edges of external and internal clocks
	wire logic ext_rise = osc_in_s & ~edge_q[0];
	wire logic int_rise = int_clk_s & ~edge_q[1];

	// Mode decodes
	wire logic crystal = is_crystal(cfg_q.mode);
	wire logic internal_mode = is_internal(cfg_q.mode);
	wire logic ext_drive = (cfg_q.mode == osccs_pkg::ext_drive_clock_mode);
	wire logic rc_out = (cfg_q.mode == osccs_pkg::resistor_capacitor_mode);
	wire logic int_out = (cfg_q.mode == osccs_pkg::internal_osc_clkout_mode);

	// Wanted internal rate and target source
	wire osccs_pkg::osccs_src_t int_src = (freq_q == osccs_pkg::FREQ_LOW_OSC) ?
		osccs_pkg::src_low_freq : osccs_pkg::src_high_freq;
	wire logic want_int = sys_sel_q | internal_mode | fail_q;
	wire osccs_pkg::osccs_src_t target = want_int ? int_src : osccs_pkg::src_external;
	wire logic target_ok = (target == osccs_pkg::src_high_freq) ? hf_ok :
		(target == osccs_pkg::src_low_freq) ? lf_ok : 1'b1;

	// Crystal count done, warm-up done
	wire logic ost_done = (ost_cnt_q == 11'(osccs_pkg::OST_EDGES));
	wire logic warm_done = (warm_cnt_q == 9'(osccs_pkg::WARM_UP_CYC));
	wire logic two_speed = cfg_q.two_speed_en & crystal;
	// Startup ends when its delay for the target has passed
	wire logic startup_end = crystal ? ost_done :
		(target != osccs_pkg::src_external) ? (warm_done & target_ok) : 1'b1;
	// Fail-safe timeout on a running external source
	wire logic ext_lost = (fail_cnt_q == 11'(osccs_pkg::FAIL_WAIT_CYC));

	// APB decode
	wire logic acc = psel & penable & ~pready_q;
	wire logic wr = acc & pwrite;
	wire logic hit_ctl = (paddr == osccs_pkg::OFS_CONTROL);
	wire logic hit_ist = (paddr == osccs_pkg::OFS_IRQ_STATUS);
	wire logic hit_msk = (paddr == osccs_pkg::OFS_IRQ_MASK);
	wire logic hit_sta = (paddr == osccs_pkg::OFS_STATE);
	wire logic mapped = hit_ctl | hit_ist | hit_msk | hit_sta;

	// Control register read image
	wire logic [7:0] ctl_rd = {1'b0, freq_q, startup_q, hf_ok, lf_ok, sys_sel_q};
	wire logic [31:0] rd_mux = hit_ctl ? {24'h0, ctl_rd} :
		hit_ist ? {29'h0, irq_stat_q} :
		hit_msk ? {29'h0, irq_mask_q} :
		hit_sta ? {25'h0, fail_q, src_q, 1'b0, state_q} : 32'h0;

	// Interrupt events
	wire logic ev_fail = (state_q == ST_RUN) & ext_lost & cfg_q.fail_safe_en &
		(src_q == osccs_pkg::src_external) & ~fail_q;
	wire logic ev_start = (state_q == ST_STARTUP) & startup_end;
	wire logic ev_switch = (state_q == ST_SWITCH) & target_ok;
	wire logic [osccs_pkg::IRQ_W-1:0] ev = {ev_switch, ev_start, ev_fail};
	wire logic [osccs_pkg::IRQ_W-1:0] clr = (wr & hit_ist) ?
		pwdata[osccs_pkg::IRQ_W-1:0] : '0;
	wire logic [osccs_pkg::IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr) | ev;

	// Fosc/4 output: divider on active source edges
	wire logic fosc_rise = (src_q == osccs_pkg::src_external) ? ext_rise : int_rise;
	wire logic clkout_mode = rc_out | int_out;

	// Next pin image
	osccs_pkg::osccs_pins_t pins_d;
	assign pins_d.out_level = clkout_mode & div_q[1] & (state_q != ST_SWITCH);
	assign pins_d.out_oe_n = ~clkout_mode;
	assign pins_d.in_pin_gpio = internal_mode;
	assign pins_d.out_pin_gpio = ext_drive | (cfg_q.mode == osccs_pkg::resistor_capacitor_io_mode) |
		(cfg_q.mode == osccs_pkg::internal_osc_pins_free_mode);

	// Gain select per crystal mode
	wire logic [1:0] gain_d =
		(cfg_q.mode == osccs_pkg::low_power_crystal_mode) ? osccs_pkg::GAIN_LOW :
		(cfg_q.mode == osccs_pkg::medium_gain_crystal_mode) ? osccs_pkg::GAIN_MID :
		(cfg_q.mode == osccs_pkg::high_gain_crystal_mode) ? osccs_pkg::GAIN_HIGH :
		osccs_pkg::GAIN_OFF;

	// Two-flop synchronisers, then edge history on second stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			edge_q <= 2'h0;
		end else if (ce) begin
			sync1_q <= {lf_ready, hf_ready, int_osc_clk, osc_in_pin};
			sync2_q <= sync1_q;
			edge_q <= sync2_q[1:0];
		end
	end

	// APB slave: one wait state, error on unmapped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else if (ce) begin
			pready_q <= acc;
			pslverr_q <= acc & ~mapped;
			prdata_q <= (acc & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// Writable control fields
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			freq_q <= osccs_pkg::RST_FREQ;
			sys_sel_q <= osccs_pkg::RST_SYS_SEL;
			irq_mask_q <= osccs_pkg::RST_IRQ;
		end else if (ce) begin
			if (wr & hit_ctl) begin
				freq_q <= pwdata[osccs_pkg::POS_FREQ_LSB +: 3];
				sys_sel_q <= pwdata[osccs_pkg::POS_SYS_SEL];
			end
			if (wr & hit_msk) begin
				irq_mask_q <= pwdata[osccs_pkg::IRQ_W-1:0];
			end
		end
	end

	// Sticky status, set beats clear; level interrupt
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= osccs_pkg::RST_IRQ;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= irq_stat_d;
			irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	// Strap capture one edge after reset release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= '0;
		end else if (ce && state_q == ST_CAPTURE) begin
			cfg_q <= cfg;
		end
	end

	// Sequencer: power-up, start-up delays, sleep, switching
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_CAPTURE;
			src_q <= osccs_pkg::src_low_freq;
			startup_q <= osccs_pkg::RST_STARTUP;
			fail_q <= 1'b0;
		end else if (ce) begin
			case (state_q)
				ST_CAPTURE: begin
					// Straps taken this edge, evaluated next
					state_q <= ST_POWER_UP_TIMER;
				end
				ST_POWER_UP_TIMER: begin
					// Start-up bit reset override
					if ((cfg_q.two_speed_en & crystal) | cfg_q.fail_safe_en) begin
						startup_q <= 1'b0;
					end
					// Count begins only after power-up timer
					if (~cfg_q.power_up_timer_en | power_up_timer_done) begin
						state_q <= ST_STARTUP;
					end
				end
				ST_STARTUP: begin
					// Two-speed runs internal meanwhile
					if (two_speed & hf_ok) begin
						src_q <= int_src;
					end
					if (startup_end) begin
						src_q <= target;
						startup_q <= (target == osccs_pkg::src_external);
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sleep_req) begin
						state_q <= ST_SLEEP;
					end else if (ev_fail) begin
						fail_q <= 1'b1;
						state_q <= ST_SWITCH;
					end else if (target != src_q) begin
						state_q <= ST_SWITCH;
					end
				end
				ST_SWITCH: begin
					// Output held low until target is stable
					if (target_ok) begin
						src_q <= target;
						startup_q <= (target == osccs_pkg::src_external);
						state_q <= ST_RUN;
					end
				end
				ST_SLEEP: begin
					if (wake_req) begin
						state_q <= ST_STARTUP;
					end
				end
				default: begin
					state_q <= ST_CAPTURE;
				end
			endcase
		end
	end

	// Crystal edge counter and warm-up counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ost_cnt_q <= 11'h0;
			warm_cnt_q <= 9'h0;
		end else if (ce) begin
			if (state_q != ST_STARTUP) begin
				ost_cnt_q <= 11'h0;
				warm_cnt_q <= 9'h0;
			end else begin
				if (crystal & ext_rise & ~ost_done) begin
					ost_cnt_q <= ost_cnt_q + 11'h1;
				end
				if (~warm_done) begin
					warm_cnt_q <= warm_cnt_q + 9'h1;
				end
			end
		end
	end

	// Fail-safe watchdog on external edges
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fail_cnt_q <= 11'h0;
		end else if (ce) begin
			if (ext_rise | (src_q != osccs_pkg::src_external) | (state_q != ST_RUN)) begin
				fail_cnt_q <= 11'h0;
			end else if (~ext_lost) begin
				fail_cnt_q <= fail_cnt_q + 11'h1;
			end
		end
	end

	// Divide-by-four of the running clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 2'h0;
		end else if (ce) begin
			if (state_q == ST_SWITCH) begin
				div_q <= 2'h0;
			end else if (fosc_rise) begin
				div_q <= div_q + 2'h1;
			end
		end
	end

	// Registered pin, gain, enable and hold outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_q <= '{out_level: 1'b0, out_oe_n: 1'b1, in_pin_gpio: 1'b0, out_pin_gpio: 1'b0};
			gain_q <= osccs_pkg::GAIN_OFF;
			hf_en_q <= 1'b0;
			lf_en_q <= 1'b1;
			hold_q <= 1'b1;
		end else if (ce) begin
			pins_q <= pins_d;
			gain_q <= gain_d;
			hf_en_q <= (target == osccs_pkg::src_high_freq) | two_speed;
			lf_en_q <= (target == osccs_pkg::src_low_freq) | cfg_q.fail_safe_en |
				cfg_q.power_up_timer_en;
			// CPU held while start-up delays run, except two-speed once HF stable
			hold_q <= (state_q == ST_CAPTURE) | (state_q == ST_POWER_UP_TIMER) | (state_q == ST_SLEEP) |
				((state_q == ST_STARTUP) & ~(two_speed & hf_ok));
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pins = pins_q;
	assign gain_sel = gain_q;
	assign sys_src = src_q;
	assign hf_enable = hf_en_q;
	assign lf_enable = lf_en_q;
	assign cpu_hold = hold_q;
	assign irq = irq_q;

endmodule
`default_nettype wire

/* core/osccs_pkg.sv */
// How it works
// - Eight clock modes chosen by strap field
// - RC mode drives fosc/4; RC-IO frees pin
// - Internal modes: fosc/4 out, or both pins free
// - External drive bypasses start-up timer, frees output
// - Control bit 7 always reads zero
// - Frequency field picks internal rate, resets 110
// - Status bit 3 shows external clock running
// - Start-up bit clears for two-speed crystal/fail-safe
// - Bit 2 shows high-frequency oscillator stable
// - Bit 1 shows low-frequency oscillator stable
// - Bit 0 selects internal clock, resets zero
// - Crystal modes count 1024 edges after reset/wake
// - CPU held while crystal count runs, unless two-speed and HF stable
// - Internal source waits warm-up delay first
// - Fully static: clock stop keeps all state
// - Crystal modes set amplifier gain low/mid/high
// - Lost external clock forces internal oscillator
package osccs_pkg;

	// Clock mode strap encoding, in strap order
	typedef enum logic [2:0] {
		ext_drive_clock_mode,
		low_power_crystal_mode,
		medium_gain_crystal_mode,
		high_gain_crystal_mode,
		resistor_capacitor_mode,
		resistor_capacitor_io_mode,
		internal_osc_clkout_mode,
		internal_osc_pins_free_mode
	} osccs_mode_t;

	// Running system clock source
	typedef enum logic [1:0] {
		src_external,
		src_high_freq,
		src_low_freq
	} osccs_src_t;

	// Non-volatile configuration straps
	typedef struct packed {
		osccs_mode_t mode;
		logic two_speed_en;
		logic fail_safe_en;
		logic power_up_timer_en;
	} osccs_cfg_t;

	// Pin control bundle
	typedef struct packed {
		logic out_level;
		logic out_oe_n;
		logic in_pin_gpio;
		logic out_pin_gpio;
	} osccs_pins_t;

	// Register byte addresses
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0c;

	// Control register field positions
	localparam int POS_FREQ_LSB = 4;
	localparam int POS_STARTUP = 3;
	localparam int POS_HF_STABLE = 2;
	localparam int POS_LF_STABLE = 1;
	localparam int POS_SYS_SEL = 0;

	// Interrupt status bit positions
	localparam int POS_IRQ_FAIL = 0;
	localparam int POS_IRQ_STARTUP_DONE = 1;
	localparam int POS_IRQ_SWITCH_DONE = 2;
	localparam int IRQ_W = 3;

	// Reset values
	localparam logic [2:0] RST_FREQ = 3'h6;
	localparam logic RST_SYS_SEL = 1'b0;
	localparam logic RST_STARTUP = 1'b1;
	localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

	// Frequency field value for low-frequency oscillator
	localparam logic [2:0] FREQ_LOW_OSC = 3'h0;

	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int OST_EDGES = 1024;
	localparam int WARM_UP_NS = 2000;
	localparam int WARM_UP_CYC = (WARM_UP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAIL_WAIT_NS = 10000;
	localparam int FAIL_WAIT_CYC = (FAIL_WAIT_NS * 1000) / CLK_PERIOD_PS;

	// Amplifier gain codes
	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_LOW = 2'h1;
	localparam logic [1:0] GAIN_MID = 2'h2;
	localparam logic [1:0] GAIN_HIGH = 2'h3;

endpackage

/* sim/osccs_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module osccs_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire osccs_pkg::osccs_cfg_t cfg,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire osccs_pkg::osccs_pins_t pins,
	input wire logic [1:0] gain_sel,
	input wire osccs_pkg::osccs_src_t sys_src,
	input wire logic cpu_hold
);
	logic [10:0] cnt_q; // Enabled cycles since reset
	logic [10:0] cnt_d;
	logic mapped; // Address hits a register
	logic xtal; // Crystal strap
	assign cnt_d = (cnt_q == 11'h7ff) ? cnt_q : cnt_q + 11'h1;
	assign mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
	assign xtal = !cfg.mode[2] && (cfg.mode[1:0] != 2'h0);
	// Saturating count of enabled cycles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 11'h0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Access phase taken
	sequence taken_s;
		psel && penable && !pready && ce;
	endsequence
	// One-cycle answer
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	bus_wait_a: assert property (taken_s |=> answer_s)
		else $error("ready pulse missing");
	hi_bits_a: assert property (
		pready && paddr == osccs_pkg::OFS_CONTROL |-> prdata[31:7] == 25'h0)
		else $error("control upper bits set");
	bad_addr_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	state_freeze_a: assert property (
		!ce |=> $stable(pins) && $stable(sys_src) && $stable(cpu_hold))
		else $error("state moved while frozen");
	gain_map_a: assert property (
		gain_sel != 2'h0 |-> xtal && gain_sel == cfg.mode[1:0])
		else $error("gain does not match mode");
	ext_fast_a: assert property (
		cnt_q == 11'h014 && cfg.mode == osccs_pkg::ext_drive_clock_mode
		&& !cfg.power_up_timer_en |-> !cpu_hold) else $error("ext drive delayed");
	xtal_hold_a: assert property (
		xtal && !cfg.two_speed_en && cnt_q < 11'h3e8 |-> cpu_hold)
		else $error("crystal start released early");
	drive_out_a: assert property (!pins.out_oe_n |->
		cfg.mode inside {osccs_pkg::resistor_capacitor_mode, osccs_pkg::internal_osc_clkout_mode})
		else $error("out pin driven in wrong mode");
	int_src_a: assert property (
		cfg.mode[2:1] == 2'h3 |-> sys_src != osccs_pkg::src_external)
		else $error("external source in internal mode");
endmodule
bind osccs_top osccs_chk i_osccs_chk (
	.clk(clk), .reset_n(reset_n), .ce(ce), .cfg(cfg), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
	.gain_sel(gain_sel), .sys_src(sys_src), .cpu_hold(cpu_hold)
);
`default_nettype wire

/* sim/osccs_xtal.sv */
`timescale 1ns/1ps
`default_nettype none
// Crystal or clock source on the input pin
module osccs_xtal #(parameter int HALF_NS = 20) (
	input wire logic run,
	output logic osc_in_pin
);
	// Oscillates while running, stands low once stopped
	initial begin
		osc_in_pin = 1'b0;
		forever begin
			#(HALF_NS);
			osc_in_pin = run ? ~osc_in_pin : 1'b0;
		end
	end
endmodule
`default_nettype wire

/* sim/oscillator_clock_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module oscillator_clock_select_bench;
	logic clk, reset_n, ce, psel, penable, pwrite, run, hf_ready, lf_ready;
	logic power_up_timer_done, sleep_req, wake_req, pready, pslverr;
	logic hf_enable, lf_enable, cpu_hold, irq, osc_in_pin, int_osc_clk, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] gain_sel;
	logic [2:0] div_q; // Internal oscillator divider
	osccs_pkg::osccs_cfg_t cfg;
	osccs_pkg::osccs_pins_t pins;
	osccs_pkg::osccs_src_t sys_src;
	int fails, checked;
	osccs_top i_osccs_top (.clk, .reset_n, .ce, .cfg, .osc_in_pin, .int_osc_clk, .hf_ready,
		.lf_ready, .power_up_timer_done, .sleep_req, .wake_req, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .gain_sel, .sys_src,
		.hf_enable, .lf_enable, .cpu_hold, .irq);
	osccs_xtal i_osccs_xtal (.run, .osc_in_pin);
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Slow internal oscillator level
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end
	assign int_osc_clk = div_q[2];
	task report_and_stop;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			report_and_stop();
		end
	endtask
	// Reset with given straps
	task boot(input logic [2:0] m, input logic ts, input logic fs, input logic pt);
		reset_n <= 1'b0;
		cfg <= {m, ts, fs, pt};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask
	task hold_wait(output int n);
		n = 0;
		while (cpu_hold !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			report_and_stop();
		end
	endtask
	task src_wait(input osccs_pkg::osccs_src_t s, output int n);
		n = 0;
		while (sys_src !== s && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			fails++;
			report_and_stop();
		end
	endtask
	// Pin use and gain for every mode
	task s_modes;
		logic [4:0] e;
		for (int m = 0; m < 8; m++) begin
			boot(m[2:0], 1'b0, 1'b0, 1'b0);
			repeat (10) @(posedge clk);
			case (m)
				0, 5: e = 5'h05;
				1, 2, 3: e = {m[1:0], 3'h4};
				4: e = 5'h00;
				6: e = 5'h02;
				default: e = 5'h07;
			endcase
			chk(32'({gain_sel, pins.out_oe_n, pins.in_pin_gpio, pins.out_pin_gpio}), 32'(e));
		end
	endtask
	// Registers, switching and interrupt
	task s_ext;
		int n;
		// Power-up timer configured: hold until it expires
		power_up_timer_done <= 1'b0;
		boot(3'h0, 1'b0, 1'b0, 1'b1);
		repeat (30) @(posedge clk);
		chk(32'(cpu_hold), 32'h1);
		power_up_timer_done <= 1'b1;
		hold_wait(n);
		chk(32'(n < 10), 32'h1);
		bus(1'b0, osccs_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h6e);
		bus(1'b0, 8'h10, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		ce <= 1'b1;
		chk(32'(sys_src), 32'(osccs_pkg::src_external));
		bus(1'b1, osccs_pkg::OFS_CONTROL, 32'hff);
		src_wait(osccs_pkg::src_high_freq, n);
		bus(1'b0, osccs_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h77);
		chk(32'({hf_enable, lf_enable}), 32'h3);
		bus(1'b0, osccs_pkg::OFS_IRQ_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h4);
		chk(32'(irq), 32'h0);
		bus(1'b1, osccs_pkg::OFS_IRQ_MASK, 32'h4);
		@(posedge clk);
		chk(32'(irq), 32'h1);
		bus(1'b1, osccs_pkg::OFS_IRQ_STATUS, 32'h4);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		hf_ready <= 1'b0;
		bus(1'b1, osccs_pkg::OFS_CONTROL, 32'h01);
		src_wait(osccs_pkg::src_low_freq, n);
		bus(1'b0, osccs_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h03);
		chk(32'({hf_enable, lf_enable}), 32'h1);
		bus(1'b1, osccs_pkg::OFS_CONTROL, 32'h71);
		repeat (50) @(posedge clk);
		chk(32'(sys_src), 32'(osccs_pkg::src_low_freq));
		hf_ready <= 1'b1;
		src_wait(osccs_pkg::src_high_freq, n);
	endtask
	// Crystal start-up count and two-speed status
	task s_xtal;
		int n;
		boot(3'h3, 1'b0, 1'b0, 1'b0);
		hold_wait(n);
		chk(32'(n > 8150 && n < 8250), 32'h1);
		bus(1'b0, osccs_pkg::OFS_CONTROL, 32'h0);
		chk(32'(rd[3]), 32'h1);
		// Sleep holds the CPU, wake reruns the crystal count
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(cpu_hold), 32'h1);
		wake_req <= 1'b1;
		@(posedge clk);
		wake_req <= 1'b0;
		hold_wait(n);
		chk(32'(n > 8150 && n < 8250), 32'h1);
		boot(3'h3, 1'b1, 1'b0, 1'b0);
		bus(1'b0, osccs_pkg::OFS_CONTROL, 32'h0);
		chk(32'(rd[3]), 32'h0);
	endtask
	// Divided clock on the out pin
	task s_div;
		int n, o, r;
		logic po, pr, s;
		for (int k = 0; k < 2; k++) begin
			boot(k ? 3'h6 : 3'h4, 1'b0, 1'b0, 1'b0);
			hold_wait(n);
			chk(32'(k ? n >= osccs_pkg::WARM_UP_CYC : n < 10), 32'h1);
			o = 0;
			r = 0;
			po = 1'b1;
			pr = 1'b1;
			repeat (512) begin
				@(posedge clk);
				s = k ? int_osc_clk : osc_in_pin;
				o += (s && !po);
				r += (pins.out_level && !pr);
				po = s;
				pr = pins.out_level;
			end
			chk(32'(r >= o / 4 - 1 && r <= o / 4 + 1), 32'h1);
		end
	endtask
	// Lost external clock
	task s_fail;
		int n;
		boot(3'h0, 1'b0, 1'b1, 1'b0);
		hold_wait(n);
		run <= 1'b0;
		src_wait(osccs_pkg::src_high_freq, n);
		chk(32'(n >= 1990), 32'h1);
		bus(1'b0, osccs_pkg::OFS_IRQ_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h1);
		run <= 1'b1;
	endtask
	// Main sequence
	initial begin
		{ce, run, hf_ready, lf_ready, power_up_timer_done} = 5'h1f;
		{reset_n, psel, penable, pwrite, sleep_req, wake_req} = 6'h0;
		{paddr, pwdata} = 40'h0;
		cfg = 7'h0;
		fails = 0;
		checked = 0;
		s_modes();
		s_ext();
		s_xtal();
		s_div();
		s_fail();
		report_and_stop();
	end
endmodule
`default_nettype wire
